// File: src/pasc_shutdown.sv
// PWM auto-shutdown control: forces four PWM pins to safe states on a fault.
// Assumes PWM levels and the period start pulse come from logic on this clock;
// fault pin and comparator outputs are asynchronous.
`timescale 1ns/10ps
`default_nettype none
module pasc_shutdown
    import pasc_pkg::*;
(
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        reset,
    // Register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    output logic      [15:0] reg_rdata,
    // PWM generator side
    input  wire logic        pwm_in_a,
    input  wire logic        pwm_in_b,
    input  wire logic        pwm_in_c,
    input  wire logic        pwm_in_d,
    input  wire logic        period_start,
    // Shutdown sources
    input  wire logic        fault_input_pin_n,
    input  wire logic        comparator_one_output,
    input  wire logic        comparator_two_output,
    // Pins toward the power stage
    output logic             pwm_out_a,
    output logic             pwm_out_a_oe,
    output logic             pwm_out_b,
    output logic             pwm_out_b_oe,
    output logic             pwm_out_c,
    output logic             pwm_out_c_oe,
    output logic             pwm_out_d,
    output logic             pwm_out_d_oe,
    // Interrupt
    output logic             irq
);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations
    logic [2:0]       sync1_q;
    logic [2:0]       sync2_q;
    logic [2:0]       sel_q,      sel_d;
    logic [1:0]       ac_safe_q,  ac_safe_d;
    logic [1:0]       bd_safe_q,  bd_safe_d;
    logic             status_q,   status_d;
    logic             auto_q,     auto_d;
    logic             hold_q,     hold_d;
    logic [IRQ_W-1:0] irq_st_q,   irq_st_d;
    logic [IRQ_W-1:0] irq_en_q,   irq_en_d;
    logic [15:0]      rdata_q,    rdata_d;
    logic [3:0]       pin_q,      pin_d;
    logic [3:0]       oe_q,       oe_d;
    logic             irq_q,      irq_d;

    pasc_src_if src ();

    ////////////////////////////////////////////////////////////////////////////
    // Two-stage synchronisers for the asynchronous sources
    always_ff @(posedge clock) begin
        if (reset) begin
            sync1_q <= 3'h1;
            sync2_q <= 3'h1;
        end else begin
            sync1_q <= {comparator_two_output, comparator_one_output, fault_input_pin_n};
            sync2_q <= sync1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Source evaluation
    assign src.sel     = sel_q;
    assign src.fault_n = sync2_q[0];
    assign src.cmp1    = sync2_q[1];
    assign src.cmp2    = sync2_q[2];

    pasc_src_eval u_eval (
        .src (src.eval)
    );

    wire src_active = src.active;

    ////////////////////////////////////////////////////////////////////////////
    // Address decode
    wire wr_ctrl    = reg_write && (reg_addr == ADDR_CTRL);
    wire wr_restart = reg_write && (reg_addr == ADDR_RESTART);
    wire wr_irq_clr = reg_write && (reg_addr == ADDR_IRQ_CLR);
    wire wr_irq_en  = reg_write && (reg_addr == ADDR_IRQ_EN);

    ////////////////////////////////////////////////////////////////////////////
    // Configuration fields
    assign sel_d     = wr_ctrl ? reg_wdata[CTRL_SEL_LSB +: 3] : sel_q;
    assign ac_safe_d = wr_ctrl ? reg_wdata[CTRL_AC_LSB +: 2]  : ac_safe_q;
    assign bd_safe_d = wr_ctrl ? reg_wdata[CTRL_BD_LSB +: 2]  : bd_safe_q;
    assign auto_d    = wr_restart ? reg_wdata[RESTART_AUTO_BIT] : auto_q;
    assign irq_en_d  = wr_irq_en ? reg_wdata[IRQ_W-1:0] : irq_en_q;

    ////////////////////////////////////////////////////////////////////////////
    // Shutdown status bit
    // Source level always wins; writes take effect only once it is gone.
    wire sw_status_wr = wr_ctrl && !src_active;
    wire auto_clear   = auto_q && !src_active;
    assign status_d = src_active              ? 1'b1 :
                      sw_status_wr            ? reg_wdata[CTRL_STATUS_BIT] :
                      auto_clear              ? 1'b0 :
                      status_q;

    ////////////////////////////////////////////////////////////////////////////
    // Output hold: enters with status, leaves only at a period start
    assign hold_d = status_q                ? 1'b1 :
                    (hold_q && period_start) ? 1'b0 :
                    hold_q;

    ////////////////////////////////////////////////////////////////////////////
    // Safe-state decode for one pin pair
    function automatic logic safe_level(input logic [1:0] code);
        safe_level = (code == SAFE_HIGH);
    endfunction

    function automatic logic safe_drive(input logic [1:0] code);
        safe_drive = (code == SAFE_LOW) || (code == SAFE_HIGH);
    endfunction

    // Pin values and enables: live PWM or safe state
    wire ac_lvl = safe_level(ac_safe_q);
    wire ac_drv = safe_drive(ac_safe_q);
    wire bd_lvl = safe_level(bd_safe_q);
    wire bd_drv = safe_drive(bd_safe_q);
    assign pin_d = hold_d ? {bd_lvl, ac_lvl, bd_lvl, ac_lvl}
                          : {pwm_in_d, pwm_in_c, pwm_in_b, pwm_in_a};
    assign oe_d  = hold_d ? {bd_drv, ac_drv, bd_drv, ac_drv}
                          : 4'hf;

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt events: shutdown entered, waveform resumed
    wire ev_enter  = status_d && !status_q;
    wire ev_resume = hold_q && !hold_d;
    wire [IRQ_W-1:0] irq_set = {ev_resume, ev_enter};
    wire [IRQ_W-1:0] irq_clr = wr_irq_clr ? reg_wdata[IRQ_W-1:0] : {IRQ_W{1'b0}};

    // Set wins over clear
    assign irq_st_d = irq_set | (irq_st_q & ~irq_clr);
    assign irq_d    = |(irq_st_d & irq_en_d);

    ////////////////////////////////////////////////////////////////////////////
    // Read mux
    wire [15:0] ctrl_word = {8'h00, status_q, sel_q, ac_safe_q, bd_safe_q};
    wire [15:0] rd_mux =
        (reg_addr == ADDR_CTRL)    ? ctrl_word :
        (reg_addr == ADDR_RESTART) ? {15'h0000, auto_q} :
        (reg_addr == ADDR_IRQ_ST)  ? {14'h0000, irq_st_q} :
        (reg_addr == ADDR_IRQ_EN)  ? {14'h0000, irq_en_q} :
        (reg_addr == ADDR_LIVE)    ? {14'h0000, hold_q, src_active} :
                                     16'h0000;
    assign rdata_d = reg_read ? rd_mux : 16'h0000;

    ////////////////////////////////////////////////////////////////////////////
    // Configuration registers
    always_ff @(posedge clock) begin
        if (reset) begin
            sel_q     <= SEL_RESET;
            ac_safe_q <= SAFE_RESET;
            bd_safe_q <= SAFE_RESET;
            auto_q    <= AUTO_RESET;
            irq_en_q  <= IRQ_EN_RESET;
        end else begin
            sel_q     <= sel_d;
            ac_safe_q <= ac_safe_d;
            bd_safe_q <= bd_safe_d;
            auto_q    <= auto_d;
            irq_en_q  <= irq_en_d;
        end
    end

    // Shutdown state
    always_ff @(posedge clock) begin
        if (reset) begin
            status_q <= 1'b0;
            hold_q   <= 1'b0;
        end else begin
            status_q <= status_d;
            hold_q   <= hold_d;
        end
    end

    // Pin drivers
    always_ff @(posedge clock) begin
        if (reset) begin
            pin_q <= 4'h0;
            oe_q  <= 4'h0;
        end else begin
            pin_q <= pin_d;
            oe_q  <= oe_d;
        end
    end

    // Interrupt and read data
    always_ff @(posedge clock) begin
        if (reset) begin
            irq_st_q <= {IRQ_W{1'b0}};
            irq_q    <= 1'b0;
            rdata_q  <= 16'h0000;
        end else begin
            irq_st_q <= irq_st_d;
            irq_q    <= irq_d;
            rdata_q  <= rdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output assignments
    assign pwm_out_a    = pin_q[0];
    assign pwm_out_b    = pin_q[1];
    assign pwm_out_c    = pin_q[2];
    assign pwm_out_d    = pin_q[3];
    assign pwm_out_a_oe = oe_q[0];
    assign pwm_out_b_oe = oe_q[1];
    assign pwm_out_c_oe = oe_q[2];
    assign pwm_out_d_oe = oe_q[3];
    assign irq          = irq_q;
    assign reg_rdata    = rdata_q;

endmodule
`default_nettype wire

// File: src/pasc_pkg.sv
// Constants for the PWM auto-shutdown control block.
// Assumes one 200 MHz clock and a simple strobed register port.
//
// Functional notes
// - In shutdown A and C pins: 1x tri-state, 01 high, 00 low.
// - In shutdown B and D pins: 1x tri-state, 01 high, 00 low.
// - Shutdown source is judged as a level, never as an edge.
// - Outputs and status stay in shutdown while the source level remains.
// - Software writes to the status bit are ignored while the source persists.
// - Once source is gone, software clear or automatic restart resumes the PWM.
// - After shutdown the waveform resumes only at the next period start.
package pasc_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register byte addresses
    localparam logic [7:0] ADDR_CTRL    = 8'h00;
    localparam logic [7:0] ADDR_RESTART = 8'h04;
    localparam logic [7:0] ADDR_IRQ_ST  = 8'h08;
    localparam logic [7:0] ADDR_IRQ_CLR = 8'h0c;
    localparam logic [7:0] ADDR_IRQ_EN  = 8'h10;
    localparam logic [7:0] ADDR_LIVE    = 8'h14;

    ////////////////////////////////////////////////////////////////////////////
    // Control and restart register field positions
    localparam int CTRL_STATUS_BIT = 7;
    localparam int CTRL_SEL_LSB    = 4;
    localparam int CTRL_AC_LSB     = 2;
    localparam int CTRL_BD_LSB     = 0;
    localparam int RESTART_AUTO_BIT = 0;

    // Interrupt status bits
    localparam int IRQ_ENTER_BIT  = 0;
    localparam int IRQ_RESUME_BIT = 1;
    localparam int IRQ_W          = 2;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [2:0] SEL_RESET     = 3'h0;
    localparam logic [1:0] SAFE_RESET    = 2'h0;
    localparam logic       AUTO_RESET    = 1'b0;
    localparam logic [1:0] IRQ_EN_RESET  = 2'h0;

    ////////////////////////////////////////////////////////////////////////////
    // Source select codes
    typedef enum logic [2:0] {
        SRC_OFF      = 3'b000,
        SRC_FAULT    = 3'b001,
        SRC_CMP1     = 3'b010,
        SRC_CMP_ANY  = 3'b011,
        SRC_FLT_CMP1 = 3'b100,
        SRC_FLT_CMP2 = 3'b101,
        SRC_ALL_A    = 3'b110,
        SRC_ALL_B    = 3'b111
    } pasc_src_e;

    // Safe-state codes for one pin pair
    localparam logic [1:0] SAFE_LOW  = 2'b00;
    localparam logic [1:0] SAFE_HIGH = 2'b01;

endpackage

// File: src/pasc_src_if.sv
// Interface joining the control block to its shutdown source evaluator.
// Assumes all members are on the block clock, already synchronised.
`timescale 1ns/10ps
`default_nettype none
interface pasc_src_if;
    logic [2:0] sel;        // Source select code
    logic       fault_n;    // Synchronised fault pin, low is fault
    logic       cmp1;       // Synchronised comparator one
    logic       cmp2;       // Synchronised comparator two
    logic       active;     // Selected source is present

    modport ctrl (output sel, output fault_n, output cmp1, output cmp2, input active);
    modport eval (input sel, input fault_n, input cmp1, input cmp2, output active);
endinterface
`default_nettype wire

// File: src/pasc_src_eval.sv
// Shutdown source evaluator: combines synchronised inputs per select code.
// Assumes inputs are already on the block clock.
`timescale 1ns/10ps
`default_nettype none
module pasc_src_eval
    import pasc_pkg::*;
(
    // Source signals
    pasc_src_if.eval src
);

    ////////////////////////////////////////////////////////////////////////////
    // Level decode of the selected source
    function automatic logic src_level(input logic [2:0] sel, input logic flt_n,
                                       input logic c1, input logic c2);
        case (pasc_src_e'(sel))
            SRC_OFF:      src_level = 1'b0;
            SRC_FAULT:    src_level = ~flt_n;
            SRC_CMP1:     src_level = c1;
            SRC_CMP_ANY:  src_level = c1 | c2;
            SRC_FLT_CMP1: src_level = ~flt_n | c1;
            SRC_FLT_CMP2: src_level = ~flt_n | c2;
            SRC_ALL_A:    src_level = ~flt_n | c1 | c2;
            SRC_ALL_B:    src_level = ~flt_n | c1 | c2;
            default:      src_level = 1'b0;
        endcase
    endfunction

    // Pure level, no edge memory
    assign src.active = src_level(src.sel, src.fault_n, src.cmp1, src.cmp2);

endmodule
`default_nettype wire

// File: bench/pasc_power_stage.sv
// Power stage model: the pads that the four PWM pins drive.
// Assumes an undriven pad floats; a changing pattern stands in for it.
`timescale 1ns/10ps
`default_nettype none
module pasc_power_stage (
    // Clock and pins from the block
    input  wire logic       clock,
    input  wire logic [3:0] pin_val,
    input  wire logic [3:0] pin_oe,
    // Pad levels seen by the load
    output logic      [3:0] pad
);
    logic [3:0] float_q = 4'h5;
    // Floating pads wander every cycle
    always @(posedge clock) float_q <= ~float_q;
    // Driven pads follow the pin, the rest float
    assign pad = (pin_val & pin_oe) | (float_q & ~pin_oe);
endmodule
`default_nettype wire

// File: bench/pasc_shutdown_props.sv
// Checker for the PWM auto-shutdown block, bound to its top ports.
// Assumes select and safe fields change only by register writes.
`timescale 1ns/10ps
`default_nettype none
module pasc_shutdown_props
    import pasc_pkg::*;
(
    // Clock, reset and register port
    input wire logic        clock, reset,
    input wire logic [7:0]  reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic        reg_write, reg_read,
    input wire logic [15:0] reg_rdata,
    // PWM side and sources
    input wire logic        pwm_in_a, pwm_in_b, pwm_in_c, pwm_in_d, period_start,
    input wire logic        fault_input_pin_n, comparator_one_output, comparator_two_output,
    // Pins and interrupt
    input wire logic        pwm_out_a, pwm_out_a_oe, pwm_out_b, pwm_out_b_oe,
    input wire logic        pwm_out_c, pwm_out_c_oe, pwm_out_d, pwm_out_d_oe, irq
);
    logic [2:0] sel_q;
    logic [3:0] safe_q;
    // Shadow of the select and safe-state fields
    always_ff @(posedge clock) begin
        if (reset) begin
            sel_q  <= 3'h0;
            safe_q <= 4'h0;
        end else if (reg_write && reg_addr == ADDR_CTRL) begin
            sel_q  <= reg_wdata[6:4];
            safe_q <= reg_wdata[3:0];
        end
    end
    // Pins match the programmed safe state
    wire ac_ok = pwm_out_a_oe == !safe_q[3] && pwm_out_c_oe == !safe_q[3]
        && pwm_out_a == (!safe_q[3] && safe_q[2]) && pwm_out_c == (!safe_q[3] && safe_q[2]);
    wire bd_ok = pwm_out_b_oe == !safe_q[1] && pwm_out_d_oe == !safe_q[1]
        && pwm_out_b == (!safe_q[1] && safe_q[0]) && pwm_out_d == (!safe_q[1] && safe_q[0]);
    wire mapped = reg_addr inside {ADDR_CTRL, ADDR_RESTART, ADDR_IRQ_ST, ADDR_IRQ_CLR,
        ADDR_IRQ_EN, ADDR_LIVE};

    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    sequence fault_held;
        (sel_q == SRC_FAULT && !fault_input_pin_n) [*4];
    endsequence
    sequence en_cleared;
        reg_write && reg_addr == ADDR_IRQ_EN && reg_wdata[1:0] == 2'h0 ##1 !reg_write;
    endsequence

    AST_AC_SAFE: assert property (fault_held |-> ##[0:2] ac_ok)
        else $error("A/C pins not in safe state");
    AST_BD_SAFE: assert property (fault_held |-> ##[0:2] bd_ok)
        else $error("B/D pins not in safe state");
    AST_LEVEL_HOLD: assert property (fault_held ##1 (sel_q == SRC_FAULT && !fault_input_pin_n) |-> ac_ok && bd_ok)
        else $error("Shutdown left while source level present");
    AST_RESUME_PERIOD: assert property ($rose(pwm_out_a_oe) && !$past(reset) && !$past(reset, 2) |-> $past(period_start))
        else $error("Pins resumed off a period start");
    AST_RD_IDLE: assert property (!$past(reg_read) |-> reg_rdata == 16'h0000)
        else $error("Read data not zero outside read answer");
    AST_RD_UPPER: assert property ($past(reg_read) |-> reg_rdata[15:8] == 8'h00)
        else $error("Upper read byte not zero");
    AST_RD_UNMAPPED: assert property ($past(reg_read) && !$past(mapped) |-> reg_rdata == 16'h0000)
        else $error("Unmapped read not zero");
    AST_OE_RESET: assert property ($past(reset) |-> !pwm_out_a_oe && !pwm_out_b_oe && !irq)
        else $error("Outputs active after reset");
    AST_IRQ_MASK: assert property (en_cleared |-> ##[0:1] !irq)
        else $error("Interrupt high with all enables off");
endmodule
`default_nettype wire
bind pasc_shutdown pasc_shutdown_props u_props (.clock, .reset, .reg_addr, .reg_wdata,
    .reg_write, .reg_read, .reg_rdata, .pwm_in_a, .pwm_in_b, .pwm_in_c, .pwm_in_d,
    .period_start, .fault_input_pin_n, .comparator_one_output, .comparator_two_output,
    .pwm_out_a, .pwm_out_a_oe, .pwm_out_b, .pwm_out_b_oe, .pwm_out_c, .pwm_out_c_oe,
    .pwm_out_d, .pwm_out_d_oe, .irq);

// File: bench/testbench.sv
// Self-checking bench for the PWM auto-shutdown block.
// Assumes the power stage model on the pins; reads checked from a queue.
`timescale 1ns/10ps
`default_nettype none
module testbench
    import pasc_pkg::*;
;
    logic clock = 1'b0, reset = 1'b1, reg_write = 1'b0, reg_read = 1'b0, period_start = 1'b0;
    logic rd_seen = 1'b0, fault_n = 1'b1, c1 = 1'b0, c2 = 1'b0, irq;
    logic [7:0] reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata;
    logic [3:0] pwm_in = 4'h0, prev_in = 4'h0, oe, val, pad;
    logic [31:0] exp_q[$];
    int n_errors = 0, comparisons = 0, seed = 77;

    always #2.5 clock = ~clock;
    // Random PWM levels, and the level the pins should show next cycle
    always @(posedge clock) begin
        prev_in <= pwm_in;
        pwm_in  <= 4'($random(seed));
    end

    pasc_shutdown uut (.clock, .reset, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
        .pwm_in_a(pwm_in[3]), .pwm_in_b(pwm_in[2]), .pwm_in_c(pwm_in[1]), .pwm_in_d(pwm_in[0]),
        .period_start, .fault_input_pin_n(fault_n), .comparator_one_output(c1),
        .comparator_two_output(c2), .pwm_out_a(val[3]), .pwm_out_a_oe(oe[3]),
        .pwm_out_b(val[2]), .pwm_out_b_oe(oe[2]), .pwm_out_c(val[1]), .pwm_out_c_oe(oe[1]),
        .pwm_out_d(val[0]), .pwm_out_d_oe(oe[0]), .irq);
    pasc_power_stage u_stage (.clock, .pin_val(val), .pin_oe(oe), .pad);

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        comparisons++;
        if (g !== e) begin
            n_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        cyc(1);
        reg_write <= 1'b0;
        cyc(1);
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] e, input logic [15:0] m);
        exp_q.push_back({m, e & m});
        reg_addr <= a;
        reg_read <= 1'b1;
        cyc(1);
        reg_read <= 1'b0;
        cyc(1);
    endtask
    task automatic pins(input logic [1:0] ac, input logic [1:0] bd);
        @(negedge clock);
        // Enables then driven levels, pins ordered a, b, c, d
        chk({8'h0, oe, pad & oe}, {8'h0, !ac[1], !bd[1], !ac[1], !bd[1],
            ac == 2'b01, bd == 2'b01, ac == 2'b01, bd == 2'b01});
        cyc(1);
    endtask
    task automatic follow();
        @(negedge clock);
        chk({8'h0, oe, pad}, {8'h0, 4'hf, prev_in});
        cyc(1);
    endtask
    function automatic logic act(input logic [2:0] s, input logic f, input logic a, input logic b);
        case (s)
            3'h0: act = 1'b0;
            3'h1: act = !f;
            3'h2: act = a;
            3'h3: act = a | b;
            3'h4: act = !f | a;
            3'h5: act = !f | b;
            default: act = !f | a | b;
        endcase
    endfunction
    task automatic report_and_stop();
        $display("errors=%0d comparisons=%0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Read answers checked against the oldest expectation
    always @(posedge clock) begin
        logic [31:0] x;
        if (rd_seen && exp_q.size() > 0) begin
            x = exp_q.pop_front();
            chk(reg_rdata & x[31:16], x[15:0]);
        end
        rd_seen <= reg_read;
    end
    // Watchdog against a hang
    initial begin
        #100000;
        n_errors++;
        report_and_stop();
    end
    // Main sequence
    initial begin
        logic [15:0] r;
        logic [1:0] ac, bd;
        cyc(5);
        reset <= 1'b0;
        cyc(1);
        for (int a = 0; a < 32; a += 4) rd(a[7:0], 16'h0000, 16'hffff);
        follow();
        r = 16'($random(seed));
        wr(ADDR_CTRL, {12'h0, r[3:0]});
        rd(ADDR_CTRL, {12'h0, r[3:0]}, 16'hffff);
        wr(ADDR_IRQ_ST, 16'h0003);
        rd(ADDR_IRQ_ST, 16'h0000, 16'hffff);
        // Every select code against every source combination
        for (int s = 0; s < 8; s++) for (int k = 0; k < 8; k++) begin
            wr(ADDR_CTRL, {9'h0, s[2:0], 4'h0});
            {fault_n, c1, c2} <= k[2:0];
            cyc(4);
            rd(ADDR_LIVE, {15'h0, act(s[2:0], k[2], k[1], k[0])}, 16'h0001);
        end
        // Sources gone through the synchroniser before the status clear
        {fault_n, c1, c2} <= 3'b100;
        cyc(4);
        wr(ADDR_CTRL, 16'h0000);
        wr(ADDR_IRQ_CLR, 16'h0003);
        period_start <= 1'b1;
        cyc(1);
        period_start <= 1'b0;
        follow();
        // Each safe-state code, refused clear, held until period start
        for (int i = 0; i < 4; i++) begin
            ac = i[1:0];
            bd = 2'h3 - i[1:0];
            wr(ADDR_IRQ_EN, {15'h0, i[0]});
            wr(ADDR_CTRL, {9'h0, SRC_FAULT, ac, bd});
            fault_n <= 1'b0;
            cyc(6);
            pins(ac, bd);
            wr(ADDR_CTRL, {9'h0, SRC_FAULT, ac, bd});
            rd(ADDR_CTRL, {8'h0, 1'b1, SRC_FAULT, ac, bd}, 16'hffff);
            chk({15'h0, irq}, {15'h0, i[0]});
            wr(ADDR_IRQ_CLR, 16'h0003);
            fault_n <= 1'b1;
            cyc(4);
            pins(ac, bd);
            wr(ADDR_CTRL, {9'h0, SRC_FAULT, ac, bd});
            cyc(3);
            pins(ac, bd);
            period_start <= 1'b1;
            cyc(1);
            period_start <= 1'b0;
            follow();
        end
        // Automatic restart once the source goes away
        wr(ADDR_IRQ_CLR, 16'h0003);
        wr(ADDR_RESTART, 16'h0001);
        wr(ADDR_CTRL, {9'h0, SRC_FAULT, 4'h0});
        fault_n <= 1'b0;
        cyc(6);
        fault_n <= 1'b1;
        cyc(6);
        rd(ADDR_CTRL, {9'h0, SRC_FAULT, 4'h0}, 16'hffff);
        pins(2'h0, 2'h0);
        period_start <= 1'b1;
        cyc(1);
        period_start <= 1'b0;
        follow();
        rd(ADDR_IRQ_ST, 16'h0003, 16'h0003);
        cyc(3);
        report_and_stop();
    end
endmodule
`default_nettype wire
